/* src/slpc_pkg.sv */
/*
  shared constants and types of the serial line port.
  assumes a single 25 mhz clock; no bus, all settings are plain ports.
*/
package slpc_pkg;
  // clock and time units
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_HZ        = 25_000_000;
  localparam int NS_PER_MS     = 1_000_000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int DELAY_MAX_MS  = 1000;
  // line rates
  localparam int RATE_MIN      = 50;
  localparam int RATE_MAX_STD  = 230400;
  localparam int RATE_MAX      = 1843200;
  localparam int RATE_DEFAULT  = 9600;
  // character shape
  localparam logic [3:0] DBITS_MIN = 4'h5;
  localparam logic [3:0] DBITS_MAX = 4'h8;
  localparam logic [2:0] STOP_HALVES_1   = 3'h2;
  localparam logic [2:0] STOP_HALVES_1P5 = 3'h3;
  localparam logic [2:0] STOP_HALVES_2   = 3'h4;
  // in-band flow characters
  localparam logic [7:0] XON_CHAR  = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  typedef enum logic [2:0] {
    SLPC_PAR_NONE = 3'h0, SLPC_PAR_EVEN = 3'h1, SLPC_PAR_ODD = 3'h2,
    SLPC_PAR_MARK = 3'h3, SLPC_PAR_SPACE = 3'h4
  } slpc_parity_t;
  typedef enum logic [1:0] {
    SLPC_STOP_1 = 2'h0, SLPC_STOP_1P5 = 2'h1, SLPC_STOP_2 = 2'h2
  } slpc_stop_t;
  typedef enum logic [1:0] {
    SLPC_FC_NONE = 2'h0, SLPC_FC_SOFT = 2'h1, SLPC_FC_HARD = 2'h2, SLPC_FC_BOTH = 2'h3
  } slpc_flow_t;
  typedef enum logic [1:0] {
    SLPC_IF_232 = 2'h0, SLPC_IF_422 = 2'h1, SLPC_IF_485 = 2'h2
  } slpc_iface_t;
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01, TX_LEAD = 7'h02, TX_START = 7'h04, TX_DATA = 7'h08,
    TX_PAR  = 7'h10, TX_STOP = 7'h20, TX_TAIL  = 7'h40
  } slpc_tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } slpc_rx_state_t;
endpackage

/* src/slpc_serial_port.sv */
/*
  serial line port: rate divider, framing, flow control, rts toggling,
  modem-status session gating, error discard and half-duplex echo.
  assumes all inputs synchronous to ref_clk and a user side that takes
  rx_data whenever rx_valid pulses (no receive back-pressure).
*/
`timescale 1ns/1ps

module slpc_serial_port
  import slpc_pkg::*;
#(
  parameter int RATE_W       = 21,
  parameter int DIV_W        = 20,
  parameter int CNT_W        = 32,
  parameter int ERRC_W       = 16,
  parameter int CYC_PER_MS_P = CYC_PER_MS  // shorten in simulation
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [RATE_W-1:0] line_rate,
  input  wire logic [3:0]        data_bits,
  input  wire slpc_parity_t      parity_mode,
  input  wire slpc_stop_t        stop_mode,
  input  wire slpc_iface_t       iface_sel,
  input  wire logic              half_duplex,
  input  wire logic              de_by_rts,
  input  wire slpc_flow_t        flow_mode,
  input  wire logic              inbound_fc_en,
  input  wire logic              outbound_fc_en,
  input  wire logic              rts_toggle_en,
  input  wire logic [9:0]        lead_ms,
  input  wire logic [9:0]        tail_ms,
  input  wire logic              mon_dsr_en,
  input  wire logic              mon_dcd_en,
  input  wire logic              discard_err_en,
  input  wire logic              echo_supp_en,
  input  wire logic              err_clr,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic [7:0]             rx_data,
  output logic                   rx_valid,
  input  wire logic              rx_throttle,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   rts_out,
  input  wire logic              cts_in,
  input  wire logic              dsr_in,
  input  wire logic              dcd_in,
  output logic                   drv_en,
  output logic                   session_up,
  output logic                   tx_paused,
  output logic                   perr_flag,
  output logic                   ferr_flag,
  output logic [ERRC_W-1:0]      perr_count,
  output logic [ERRC_W-1:0]      ferr_count,
  output logic [DIV_W-1:0]       rate_div
);

  // parity bit for the low n bits of d
  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                   input slpc_parity_t m);
    logic [7:0] mask;
    logic       x;
    mask = 8'hFF >> (DBITS_MAX - n);
    x    = ^(d & mask);
    case (m)
      SLPC_PAR_EVEN: par_bit = x;
      SLPC_PAR_ODD:  par_bit = ~x;
      SLPC_PAR_MARK: par_bit = 1'b1;
      default:       par_bit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shared decode of the settings
  logic [3:0]       nbits;     // data bits, clamped 5..8
  logic [31:0]      rate32;    // clamped rate request
  logic [31:0]      div32;     // nearest whole divisor
  logic [CNT_W-1:0] div_c;     // one bit time in cycles
  logic [CNT_W-1:0] stop_c;    // stop interval in cycles
  logic [CNT_W-1:0] lead_c;    // lead delay in cycles
  logic [CNT_W-1:0] tail_c;    // tail delay in cycles
  logic [2:0]       halves;    // stop length in half bits
  logic             hd;        // two-wire half duplex
  logic             par_on;    // parity position present
  logic             soft_out, soft_in, hard_out, hard_in;

  // settings decode; division is costly but only follows config changes
  always_comb begin
    nbits  = (data_bits < DBITS_MIN) ? DBITS_MIN :
             (data_bits > DBITS_MAX) ? DBITS_MAX : data_bits;
    rate32 = 32'(line_rate);
    if (rate32 < 32'(RATE_MIN)) rate32 = 32'(RATE_MIN);
    if (rate32 > 32'(RATE_MAX)) rate32 = 32'(RATE_MAX);
    div32  = (32'(CLK_HZ) + (rate32 >> 1)) / rate32;
    div_c  = CNT_W'(rate_div);
    case (stop_mode)
      SLPC_STOP_1P5: halves = STOP_HALVES_1P5;
      SLPC_STOP_2:   halves = STOP_HALVES_2;
      default:       halves = STOP_HALVES_1;
    endcase
    stop_c = CNT_W'((div_c >> 1) * CNT_W'(halves));
    lead_c = CNT_W'(((lead_ms > 10'(DELAY_MAX_MS)) ? DELAY_MAX_MS : int'(lead_ms))
                    * CYC_PER_MS_P);
    tail_c = CNT_W'(((tail_ms > 10'(DELAY_MAX_MS)) ? DELAY_MAX_MS : int'(tail_ms))
                    * CYC_PER_MS_P);
    // half duplex only on the multidrop interface
    hd       = (iface_sel == SLPC_IF_485) && half_duplex;
    par_on   = (parity_mode != SLPC_PAR_NONE);
    soft_out = flow_mode[0] && outbound_fc_en;
    soft_in  = flow_mode[0] && inbound_fc_en;
    hard_out = flow_mode[1] && outbound_fc_en;
    hard_in  = flow_mode[1] && inbound_fc_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter state
  slpc_tx_state_t   tx_state_reg, tx_state_next;
  logic [CNT_W-1:0] tcnt_reg, tcnt_next;     // cycles in current phase
  logic [7:0]       tsh_reg, tsh_next;       // outgoing shift register
  logic [3:0]       tbit_reg, tbit_next;     // data bit index
  logic             tpar_reg, tpar_next;     // parity bit to send
  logic             xoff_pend_reg, xoff_pend_next;
  logic             xon_pend_reg, xon_pend_next;
  logic             thr_d_reg, thr_d_next;   // throttle, one cycle old
  logic             txd_reg, txd_next;
  logic             rts_reg, rts_next;
  logic             de_reg, de_next;
  logic             tx_gate, start_ok, tx_busy;
  slpc_rx_state_t   rx_state_reg;
  logic             paused_reg, session_reg;

  assign tx_busy = (tx_state_reg == TX_START) || (tx_state_reg == TX_DATA) ||
                   (tx_state_reg == TX_PAR) || (tx_state_reg == TX_STOP);

  // next values of the transmitter
  always_comb begin
    tx_state_next  = tx_state_reg;
    tcnt_next      = tcnt_reg + 1'b1;
    tsh_next       = tsh_reg;
    tbit_next      = tbit_reg;
    tpar_next      = tpar_reg;
    xoff_pend_next = xoff_pend_reg;
    xon_pend_next  = xon_pend_reg;
    thr_d_next     = rx_throttle;
    tx_ready       = 1'b0;
    // soft inbound throttling queues xoff / xon
    if (soft_in && rx_throttle && !thr_d_reg) begin
      xoff_pend_next = 1'b1;
      xon_pend_next  = 1'b0;
    end else if (soft_in && !rx_throttle && thr_d_reg) begin
      xon_pend_next  = 1'b1;
      xoff_pend_next = 1'b0;
    end
    // no traffic before session start; one direction
    tx_gate  = session_reg && !(hd && rx_state_reg != RX_IDLE) &&
               (rts_toggle_en || !hard_out || cts_in);
    start_ok = tx_gate && (xoff_pend_reg || xon_pend_reg || (tx_valid && !paused_reg));
    case (tx_state_reg)
      TX_IDLE, TX_TAIL: begin
        if (start_ok) begin
          // flow characters go ahead of user data, even when paused
          if (xoff_pend_reg) begin
            tsh_next       = XOFF_CHAR;
            xoff_pend_next = 1'b0;
          end else if (xon_pend_reg) begin
            tsh_next      = XON_CHAR;
            xon_pend_next = 1'b0;
          end else begin
            tsh_next = tx_data;
            tx_ready = 1'b1;
          end
          tpar_next = par_bit(tsh_next, nbits, parity_mode);
          tcnt_next = '0;
          // raise rts first; already high during tail
          tx_state_next = (rts_toggle_en && tx_state_reg == TX_IDLE) ? TX_LEAD : TX_START;
        end else if (tx_state_reg == TX_TAIL && tcnt_reg >= tail_c) begin
          tx_state_next = TX_IDLE;
        end
      end
      TX_LEAD: begin
        // hard flow replaces the lead delay with cts
        if (hard_out ? cts_in : (tcnt_reg >= lead_c)) begin
          tx_state_next = TX_START;
          tcnt_next     = '0;
        end
      end
      TX_START: begin
        if (tcnt_reg >= div_c - 1'b1) begin
          tx_state_next = TX_DATA;
          tcnt_next     = '0;
          tbit_next     = '0;
        end
      end
      TX_DATA: begin
        if (tcnt_reg >= div_c - 1'b1) begin
          tcnt_next = '0;
          tsh_next  = tsh_reg >> 1;
          tbit_next = tbit_reg + 1'b1;
          if (tbit_reg == nbits - 1'b1) tx_state_next = par_on ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR: begin
        if (tcnt_reg >= div_c - 1'b1) begin
          tx_state_next = TX_STOP;
          tcnt_next     = '0;
        end
      end
      TX_STOP: begin
        if (tcnt_reg >= stop_c - 1'b1) begin
          tx_state_next = rts_toggle_en ? TX_TAIL : TX_IDLE;
          tcnt_next     = '0;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    // line level follows the state about to be entered
    case (tx_state_next)
      TX_START: txd_next = 1'b0;
      TX_DATA:  txd_next = tsh_next[0];
      // parity position carries computed or forced bit
      TX_PAR:   txd_next = tpar_next;
      default:  txd_next = 1'b1;
    endcase
    // toggle mode: rts high from lead through tail
    if (rts_toggle_en) rts_next = (tx_state_next != TX_IDLE);
    else               rts_next = hard_in ? !rx_throttle : 1'b1;
    // driver enable automatic or following rts
    if (iface_sel != SLPC_IF_485) de_next = 1'b1;
    else if (de_by_rts)           de_next = rts_next;
    else de_next = (tx_state_next != TX_IDLE) && (tx_state_next != TX_LEAD) &&
                   (tx_state_next != TX_TAIL);
  end

  // transmitter registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_state_reg  <= TX_IDLE;
      tcnt_reg      <= '0;
      tsh_reg       <= '0;
      tbit_reg      <= '0;
      tpar_reg      <= 1'b0;
      xoff_pend_reg <= 1'b0;
      xon_pend_reg  <= 1'b0;
      thr_d_reg     <= 1'b0;
      txd_reg       <= 1'b1;
      rts_reg       <= 1'b0;
      de_reg        <= 1'b0;
    end else begin
      tx_state_reg  <= tx_state_next;
      tcnt_reg      <= tcnt_next;
      tsh_reg       <= tsh_next;
      tbit_reg      <= tbit_next;
      tpar_reg      <= tpar_next;
      xoff_pend_reg <= xoff_pend_next;
      xon_pend_reg  <= xon_pend_next;
      thr_d_reg     <= thr_d_next;
      txd_reg       <= txd_next;
      rts_reg       <= rts_next;
      de_reg        <= de_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver, session and status state
  slpc_rx_state_t    rx_state_next;
  logic [CNT_W-1:0]  rcnt_reg, rcnt_next;
  logic [7:0]        rsh_reg, rsh_next;
  logic [3:0]        rbit_reg, rbit_next;
  logic              rpbad_reg, rpbad_next;   // parity bad this char
  logic              recho_reg, recho_next;   // char began during own tx
  logic [7:0]        rxdat_reg, rxdat_next;
  logic              rxv_reg, rxv_next;
  logic              paused_next, session_next;
  logic              perr_reg, perr_next, ferr_reg, ferr_next;
  logic [ERRC_W-1:0] pcnt_reg, pcnt_next, fcnt_reg, fcnt_next;
  logic [DIV_W-1:0]  div_reg;
  logic              rx_line, rx_done, fbad, flow_chr, drop;

  // next values of the receiver
  always_comb begin
    rx_state_next = rx_state_reg;
    rcnt_next     = rcnt_reg + 1'b1;
    rsh_next      = rsh_reg;
    rbit_next     = rbit_reg;
    rpbad_next    = rpbad_reg;
    recho_next    = recho_reg;
    rxdat_next    = rxdat_reg;
    rxv_next      = 1'b0;
    paused_next   = paused_reg && soft_out;
    rx_done       = 1'b0;
    fbad          = 1'b0;
    // session latches once monitored lines agree
    session_next  = session_reg || ((!mon_dsr_en || dsr_in) && (!mon_dcd_en || dcd_in));
    // half duplex: own transmission loops into the receiver
    rx_line = (hd && tx_busy) ? txd_reg : rxd;
    case (rx_state_reg)
      RX_IDLE: begin
        if (session_reg && !rx_line) begin
          rx_state_next = RX_START;
          rcnt_next     = '0;
          rsh_next      = '0;
          rpbad_next    = 1'b0;
          recho_next    = hd && tx_busy;
        end
      end
      RX_START: begin
        // confirm start at mid bit
        if (rcnt_reg >= (div_c >> 1) - 1'b1) begin
          rx_state_next = rx_line ? RX_IDLE : RX_DATA;
          rcnt_next     = '0;
          rbit_next     = '0;
        end
      end
      RX_DATA: begin
        if (rcnt_reg >= div_c - 1'b1) begin
          rcnt_next           = '0;
          rsh_next[rbit_reg[2:0]] = rx_line;
          rbit_next           = rbit_reg + 1'b1;
          if (rbit_reg == nbits - 1'b1) rx_state_next = par_on ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (rcnt_reg >= div_c - 1'b1) begin
          rcnt_next     = '0;
          rpbad_next    = (rx_line != par_bit(rsh_reg, nbits, parity_mode));
          rx_state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rcnt_reg >= div_c - 1'b1) begin
          rx_done       = 1'b1;
          fbad          = !rx_line;
          rx_state_next = RX_IDLE;
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
    // soft outbound: xoff pauses, xon resumes, neither delivered
    flow_chr = soft_out && ((rsh_reg == XON_CHAR) || (rsh_reg == XOFF_CHAR));
    drop = (discard_err_en && (rpbad_reg || fbad)) ||
           (echo_supp_en && hd && recho_reg) || flow_chr;
    if (rx_done) begin
      if (flow_chr) paused_next = (rsh_reg == XOFF_CHAR);
      rxv_next = !drop;
      if (!drop) rxdat_next = rsh_reg;
    end
    // sticky flags, a new error wins over clear
    perr_next = (perr_reg && !err_clr) || (rx_done && rpbad_reg);
    ferr_next = (ferr_reg && !err_clr) || (rx_done && fbad);
    pcnt_next = pcnt_reg + ERRC_W'(rx_done && rpbad_reg);
    fcnt_next = fcnt_reg + ERRC_W'(rx_done && fbad);
  end

  // receiver registers; divisor is registered for timing and readback
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rcnt_reg     <= '0;
      rsh_reg      <= '0;
      rbit_reg     <= '0;
      rpbad_reg    <= 1'b0;
      recho_reg    <= 1'b0;
      rxdat_reg    <= '0;
      rxv_reg      <= 1'b0;
      paused_reg   <= 1'b0;
      session_reg  <= 1'b0;
      perr_reg     <= 1'b0;
      ferr_reg     <= 1'b0;
      pcnt_reg     <= '0;
      fcnt_reg     <= '0;
      div_reg      <= DIV_W'(CLK_HZ / RATE_DEFAULT);
    end else begin
      rx_state_reg <= rx_state_next;
      rcnt_reg     <= rcnt_next;
      rsh_reg      <= rsh_next;
      rbit_reg     <= rbit_next;
      rpbad_reg    <= rpbad_next;
      recho_reg    <= recho_next;
      rxdat_reg    <= rxdat_next;
      rxv_reg      <= rxv_next;
      paused_reg   <= paused_next;
      session_reg  <= session_next;
      perr_reg     <= perr_next;
      ferr_reg     <= ferr_next;
      pcnt_reg     <= pcnt_next;
      fcnt_reg     <= fcnt_next;
      div_reg      <= DIV_W'(div32);
    end
  end

  assign rate_div   = div_reg;
  assign txd        = txd_reg;
  assign rts_out    = rts_reg;
  assign drv_en     = de_reg;
  assign rx_data    = rxdat_reg;
  assign rx_valid   = rxv_reg;
  assign session_up = session_reg;
  assign tx_paused  = paused_reg;
  assign perr_flag  = perr_reg;
  assign ferr_flag  = ferr_reg;
  assign perr_count = pcnt_reg;
  assign ferr_count = fcnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_rts_during_tx: assert property (rts_toggle_en && tx_busy |-> rts_out)
    else $error("rts low while toggling transmit");
  a_lead_wait: assert property (
    tx_state_reg == TX_LEAD && tx_state_next == TX_START && !hard_out |-> tcnt_reg >= lead_c)
    else $error("lead delay cut short");
  a_cts_start: assert property (
    tx_state_reg == TX_LEAD && hard_out && cts_in |=> tx_state_reg == TX_START)
    else $error("no start on cts");
  a_tail_drop: assert property (
    tx_state_reg == TX_TAIL && tx_state_next == TX_IDLE |-> tcnt_reg >= tail_c ##1 !rts_out)
    else $error("rts dropped before tail");
  a_mark_parity: assert property (
    tx_state_reg == TX_PAR && parity_mode == SLPC_PAR_MARK |-> txd)
    else $error("mark parity not one");
  a_half_one_way: assert property (
    hd && tx_state_reg == TX_IDLE && rx_state_reg != RX_IDLE |=> !tx_busy)
    else $error("half duplex transmit while receiving");
  a_session_gate: assert property (!session_reg |-> tx_state_reg == TX_IDLE)
    else $error("transmit before session");
  a_discard_err: assert property (
    rx_done && discard_err_en && (rpbad_reg || fbad) |=> !rx_valid)
    else $error("error character passed");
  a_echo_drop: assert property (
    rx_done && echo_supp_en && hd && recho_reg |=> !rx_valid)
    else $error("own echo passed");
  // a clear in the cycle after the set is legal, so the second cycle allows for it
  a_sticky_perr: assert property (
    rx_done && rpbad_reg |=> perr_flag ##1 (perr_flag || $past(err_clr)))
    else $error("parity flag not sticky");

  c_char_out:  cover property (tx_state_reg == TX_STOP ##1 tx_state_reg == TX_IDLE);
  c_char_in:   cover property (rx_valid);
  c_toggle:    cover property (tx_state_reg == TX_LEAD ##[1:1000] tx_state_reg == TX_TAIL);
  c_echo_seen: cover property (rx_done && recho_reg);

endmodule

/* verification/slpc_line_dev.sv */
/*
  serial device on the far side of the line: sends frames on rxd, captures frames on txd.
  assumes a fixed bit time in ref_clk cycles that matches the port's divider.
*/
`timescale 1ns/1ps
module slpc_line_dev #(
  parameter int BIT = 14  // cycles per bit
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [10:0] got;    // last frame seen, start bit at index 0
  int          n_got;  // frames seen so far
  initial begin
    rxd   = 1'b1;
    n_got = 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // whole frames captured
  initial forever begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      got[i] = txd;
      repeat (BIT) @(posedge ref_clk);
    end
    n_got++;
  end
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT) @(posedge ref_clk);
    end
    rxd <= 1'b1;  // line idles high
  endtask
endmodule

/* verification/slpc_serial_port_tb.sv */
/*
  testbench of the serial port: framing, receive, errors, echo, flow, rts lead.
  assumes 25 mhz ref_clk and the line device model on rxd/txd.
*/
`timescale 1ns/1ps
module slpc_serial_port_tb;
  import slpc_pkg::*;
  logic ref_clk, rst, half_duplex, de_by_rts, inbound_fc_en, outbound_fc_en;
  logic rts_toggle_en, mon_dsr_en, mon_dcd_en, discard_err_en, echo_supp_en, err_clr;
  logic tx_valid, tx_ready, rx_valid, rx_throttle, rxd, txd, rts_out, cts_in, dsr_in;
  logic dcd_in, drv_en, session_up, tx_paused, perr_flag, ferr_flag;
  logic [20:0] line_rate;
  logic [3:0]  data_bits;
  logic [9:0]  lead_ms, tail_ms;
  logic [7:0]  tx_data, rx_data, rx_last;
  logic [15:0] perr_count, ferr_count;
  logic [19:0] rate_div;
  slpc_parity_t parity_mode;
  slpc_stop_t   stop_mode;
  slpc_iface_t  iface_sel;
  slpc_flow_t   flow_mode;
  int n_errors, n_compared, rx_cnt, n0, k, n;
  logic [10:0] f;
  slpc_serial_port #(.CYC_PER_MS_P(10)) i_slpc_serial_port (.*);
  slpc_line_dev #(.BIT(14)) i_slpc_line_dev (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // count delivered characters
  always @(posedge ref_clk) if (rx_valid === 1'b1) begin
    rx_cnt++;
    rx_last = rx_data;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // offer a character and hold it until taken
  task automatic send_tx(input logic [7:0] d);
    @(posedge ref_clk);
    tx_data  <= d;
    tx_valid <= 1'b1;
    k = 0;
    do @(negedge ref_clk); while (tx_ready !== 1'b1 && k++ < 5000);
    @(posedge ref_clk);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_dev();
    k = n0;
    n0 = i_slpc_line_dev.n_got;
    for (int i = 0; i < 800 && i_slpc_line_dev.n_got == n0; i++) @(posedge ref_clk);
    n0 = i_slpc_line_dev.n_got;
  endtask
  // expected line frame: start, data lsb first, parity, stop
  function automatic logic [10:0] frame(logic [7:0] d, int nb, slpc_parity_t p, logic st);
    logic [10:0] r;
    r = 11'h7ff;
    d = d & (8'hff >> (8 - nb));
    r[0] = 1'b0;
    for (int i = 0; i < nb; i++) r[i + 1] = d[i];
    n = nb + 1;
    if (p != SLPC_PAR_NONE) begin
      r[n] = (p == SLPC_PAR_EVEN) ? ^d : (p == SLPC_PAR_ODD) ? ~^d : (p == SLPC_PAR_MARK);
      n++;
    end
    r[n] = st;
    n++;
    return r;
  endfunction
  initial begin
    {rst, half_duplex, de_by_rts, rts_toggle_en, discard_err_en, echo_supp_en} = 6'h3f;
    {half_duplex, de_by_rts, rts_toggle_en, echo_supp_en, err_clr, rx_throttle} = '0;
    {inbound_fc_en, outbound_fc_en, mon_dsr_en, mon_dcd_en, dsr_in, cts_in} = 6'h3f;
    {dcd_in, tx_valid, tx_data, lead_ms, tail_ms} = '0;
    {line_rate, data_bits} = {21'h1c_2000, 4'h8};
    parity_mode = SLPC_PAR_NONE;
    stop_mode   = SLPC_STOP_1;
    iface_sel   = SLPC_IF_232;
    flow_mode   = SLPC_FC_NONE;
    {n_errors, n_compared, rx_cnt, n0} = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(session_up === 1'b0, "session up without dcd");
    chk(rate_div === 20'h0_000e, "custom divider");
    dcd_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(session_up === 1'b1, "session not started");
    $display("test session done");
    for (int nb = 8; nb >= 7; nb--) for (int p = 0; p < 5; p++) begin
      parity_mode <= slpc_parity_t'(p);
      data_bits   <= nb[3:0];
      send_tx(8'ha5 ^ p[7:0]);
      wait_dev();
      f = frame(8'ha5 ^ p[7:0], nb, slpc_parity_t'(p), 1'b1);
      chk(((i_slpc_line_dev.got ^ f) & (11'h7ff >> (11 - n))) === 0, "tx frame");
    end
    $display("test tx framing done");
    // the framing loop leaves seven bits and space parity behind
    parity_mode <= SLPC_PAR_ODD;
    data_bits   <= 4'h8;
    f = frame(8'h3c, 8, SLPC_PAR_ODD, 1'b1);
    i_slpc_line_dev.send(f, n);
    repeat (20) @(posedge ref_clk);
    chk(rx_last === 8'h3c && rx_cnt == 1, "rx char");
    f[9] = ~f[9];
    i_slpc_line_dev.send(f, n);
    repeat (20) @(posedge ref_clk);
    chk(rx_cnt == 1 && perr_flag === 1'b1, "parity error kept");
    f = frame(8'h3c, 8, SLPC_PAR_ODD, 1'b0);
    i_slpc_line_dev.send(f, n);
    repeat (40) @(posedge ref_clk);
    chk(rx_cnt == 1 && ferr_flag === 1'b1, "framing error kept");
    err_clr <= 1'b1;
    @(posedge ref_clk);
    err_clr <= 1'b0;
    @(posedge ref_clk);
    chk(perr_flag === 1'b0 && ferr_flag === 1'b0, "flags not cleared");
    chk(perr_count === 16'h0001 && ferr_count === 16'h0001, "error counts");
    $display("test rx done");
    parity_mode <= SLPC_PAR_NONE;
    iface_sel   <= SLPC_IF_485;
    half_duplex <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      echo_supp_en <= e[0];
      send_tx(8'h5a);
      @(negedge ref_clk);
      chk(drv_en === 1'b1, "driver off while sending");
      wait_dev();
      repeat (20) @(posedge ref_clk);
      chk(rx_cnt == 2 && rx_last === 8'h5a && drv_en === 1'b0, "echo handling");
    end
    $display("test echo done");
    iface_sel   <= SLPC_IF_232;
    half_duplex <= 1'b0;
    flow_mode   <= SLPC_FC_SOFT;
    // in-band flow characters pause and resume, and are never delivered
    f = frame(XOFF_CHAR, 8, SLPC_PAR_NONE, 1'b1);
    i_slpc_line_dev.send(f, n);
    repeat (20) @(posedge ref_clk);
    chk(tx_paused === 1'b1 && rx_cnt == 2, "xoff not taken");
    f = frame(XON_CHAR, 8, SLPC_PAR_NONE, 1'b1);
    i_slpc_line_dev.send(f, n);
    repeat (20) @(posedge ref_clk);
    chk(tx_paused === 1'b0 && rx_cnt == 2, "xon not taken");
    flow_mode <= SLPC_FC_HARD;
    cts_in    <= 1'b0;
    tx_valid  <= 1'b1;
    repeat (50) @(negedge ref_clk) chk(tx_ready !== 1'b1, "sent without cts");
    // withdraw the held request so that only the next character goes out
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    cts_in   <= 1'b1;
    send_tx(8'h81);
    wait_dev();
    chk(i_slpc_line_dev.got[8:0] === 9'h102, "tx after cts");
    flow_mode     <= SLPC_FC_NONE;
    rts_toggle_en <= 1'b1;
    lead_ms       <= 10'h002;
    tail_ms       <= 10'h001;
    send_tx(8'h42);
    for (k = 0; txd !== 1'b0 && k < 500; k++) @(negedge ref_clk);
    chk(k >= 20 && k <= 22 && rts_out === 1'b1, "rts lead delay");
    // frame of ten bits is 140 cycles, then a tail of 10 cycles
    repeat (145) @(negedge ref_clk);
    chk(rts_out === 1'b1, "rts dropped before tail");
    repeat (10) @(negedge ref_clk);
    chk(rts_out === 1'b0, "rts held after tail");
    @(posedge ref_clk);
    flow_mode <= SLPC_FC_HARD;
    cts_in    <= 1'b0;
    send_tx(8'h24);
    repeat (40) @(negedge ref_clk);
    chk(txd === 1'b1 && rts_out === 1'b1, "lead not held for cts");
    @(posedge ref_clk);
    cts_in <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(txd === 1'b0, "no start on cts");
    $display("test flow done");
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
endmodule
